// >>> bench/tb.sv
// Self-checking bench for the trip log and status block.
// Assumes the design header is on the include path.
`include "tlsd_consts.vh"
`define CHK(n, x, y) begin compares++; if ((y) !== (x)) begin err_total++; \
   $display("unexpected %s exp %h got %h", n, x, y); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, trip_event = 0, sub_trip_valid = 0, trip_clear = 0, mon_sample = 0;
   logic [7:0] trip_code = 0, sub_trip = 0, c;
   logic [15:0] date_in = 0, time_in = 0;
   logic [287:0] mon_live = 0;
   logic hw_enable = 0, final_run = 0, zero_speed = 0, supply_loss = 0, dc_braking = 0, undervoltage = 0;
   logic power_stage_ready = 0, option_fitted = 0, option_ready = 0, db_update = 0;
   wire logic psel, penable, pwrite, pready, pslverr, output_enable, irq;
   wire logic [11:0] paddr;
   wire logic [31:0] pwdata, prdata;
   wire logic [287:0] mon_out;
   wire logic [3:0] status_code;
   wire logic [7:0] shown_trip_code;
   logic [3:0] cond_code [4] = '{`TLSD_ST_STOPPED, `TLSD_ST_SUPPLY_LOSS, `TLSD_ST_DC_BRAKE, `TLSD_ST_UNDERV};
   logic [31:0] q;
   logic e;
   int err_total = 0, compares = 0;
   always #5 clk = ~clk;
   tlsd_trip_log u_tlsd_trip_log (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .trip_event, .trip_code, .sub_trip_valid, .sub_trip, .trip_clear, .date_in, .time_in,
      .mon_sample, .mon_live, .mon_out, .hw_enable, .final_run, .zero_speed, .supply_loss, .dc_braking,
      .undervoltage, .power_stage_ready, .option_fitted, .option_ready, .db_update, .status_code,
      .shown_trip_code, .output_enable, .irq);
   tlsd_apb_host u_tlsd_apb_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      u_tlsd_apb_host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(logic [11:0] a);
      u_tlsd_apb_host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   // Back-to-back trips; odd codes carry a sub-trip, even ones offer one that must not be logged
   task automatic trips(int n, logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         trip_event <= 1'b1;
         trip_code <= base + 8'(i);
         sub_trip <= base + 8'(i) + 8'h40;
         sub_trip_valid <= i[0];
         date_in <= {8'hd0, base + 8'(i)};
         time_in <= {8'he0, base + 8'(i)};
         @(posedge clk);
      end
      trip_event <= 1'b0;
   endtask
   task automatic pulse_sample(logic [15:0] v);
      mon_live <= {18{v}};
      mon_sample <= 1'b1;
      @(posedge clk);
      mon_sample <= 1'b0;
      tick(2);
   endtask
   // Trip, sub-trip, date and time banks sit 0x40 apart; newest code 8'h2a
   task automatic chk_log(logic clr);
      for (int b = 0; b < 4; b++) begin
         for (int j = 0; j < 10; j++) begin
            c = 8'h2a - 8'(j);
            rd(`TLSD_OFF_TRIP_BASE + 12'(64 * b + 4 * j));
            `CHK("log", clr ? 32'h0 : (b == 0 ? 32'(c) : b == 1 ? (c[0] ? 32'(c + 8'h40) : 32'h0) : 
               32'({(b == 2 ? 8'hd0 : 8'he0), c})), q)
         end
      end
   endtask
   task automatic final_report;
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #200us;
      err_total++;
      final_report;
   end
   initial begin
      tick(5);
      rst_n <= 1'b1;
      tick(3);
      `CHK("wait_ps", `TLSD_ST_WAIT_PS, status_code)
      power_stage_ready <= 1'b1;
      option_fitted <= 1'b1;
      tick(3);
      `CHK("wait_opt", `TLSD_ST_WAIT_OPT, status_code)
      option_ready <= 1'b1;
      db_update <= 1'b1;
      tick(3);
      `CHK("load_db", `TLSD_ST_LOAD_DB, status_code)
      db_update <= 1'b0;
      hw_enable <= 1'b1;
      tick(3);
      `CHK("inh_sw", `TLSD_ST_INHIBIT, status_code)
      wr(`TLSD_OFF_CTRL, 32'h1);
      tick(2);
      `CHK("ready", `TLSD_ST_READY, status_code)
      hw_enable <= 1'b0;
      tick(3);
      `CHK("inh_hw", `TLSD_ST_INHIBIT, status_code)
      hw_enable <= 1'b1;
      final_run <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         {undervoltage, dc_braking, supply_loss, zero_speed} <= 4'hf >> (3 - i);
         tick(3);
         `CHK("cond", cond_code[i], status_code)
         `CHK("cond_oe", 1'(i < 3), output_enable)
      end
      {undervoltage, dc_braking, supply_loss, zero_speed} <= 4'h0;
      wr(`TLSD_OFF_IRQ_MASK, 32'h1);
      pulse_sample(16'ha5c3);
      trips(11, 8'h20);
      pulse_sample(16'h1234);
      `CHK("frozen", {18{16'ha5c3}}, mon_out)
      `CHK("err", `TLSD_ST_TRIPPED, status_code)
      `CHK("err_code", 8'h2a, shown_trip_code)
      `CHK("err_oe", 1'b0, output_enable)
      `CHK("irq_on", 1'b1, irq)
      chk_log(1'b0);
      wr(`TLSD_OFF_IRQ_MASK, 32'h0);
      tick(2);
      `CHK("irq_masked", 1'b0, irq)
      wr(`TLSD_OFF_IRQ_MASK, 32'h7);
      tick(2);
      `CHK("irq_unmasked", 1'b1, irq)
      rd(`TLSD_OFF_IRQ_STAT);
      `CHK("irq_stat", 32'h1, q)
      tick(2);
      `CHK("irq_cleared", 1'b0, irq)
      // Clear the trip, then sample in the very next cycle
      trip_clear <= 1'b1;
      @(posedge clk);
      trip_clear <= 1'b0;
      pulse_sample(16'h5a5a);
      `CHK("live", {18{16'h5a5a}}, mon_out)
      `CHK("run", `TLSD_ST_RUNNING, status_code)
      wr(`TLSD_OFF_CTRL, 32'h1001);
      trips(1, 8'h30);
      pulse_sample(16'h0f0f);
      `CHK("no_freeze", {18{16'h0f0f}}, mon_out)
      trip_clear <= 1'b1;
      @(posedge clk);
      trip_clear <= 1'b0;
      wr(`TLSD_OFF_LOG_RESET, 32'hfe);
      rd(`TLSD_OFF_TRIP_BASE);
      `CHK("bad_key", 32'h30, q)
      wr(`TLSD_OFF_LOG_RESET, 32'hff);
      chk_log(1'b1);
      rd(`TLSD_OFF_IRQ_STAT);
      `CHK("irq_events", 32'h7, q)
      rd(12'hffc);
      `CHK("unmapped_err", 1'b1, e)
      `CHK("unmapped_data", 32'h0, q)
      final_report;
   end
endmodule

// >>> bench/tlsd_apb_host.sv
// Serial host model: an APB master issuing one transfer per call.
// Assumes the bench calls xfer right after a rising clock edge.
module tlsd_apb_host (
   // Clock
   input  wire logic        clk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   // Request held until pready seen; released lines show the inverse so stale data never passes
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// >>> bench/tlsd_trip_log_props.sv
// Port-level assertions for the trip log and status block.
// Assumes it is bound into tlsd_trip_log; a single clock domain.
`include "tlsd_consts.vh"
module tlsd_trip_log_props (
   // Clock, reset and causes
   input wire logic          clk, rst_n, trip_event, trip_clear, mon_sample,
   input wire logic          hw_enable, undervoltage, power_stage_ready, db_update,
   input wire logic [7:0]    trip_code,
   input wire logic [287:0]  mon_live,
   // Observed outputs
   input wire logic          output_enable,
   input wire logic [7:0]    shown_trip_code,
   input wire logic [3:0]    status_code,
   input wire logic [287:0]  mon_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Trip reaction; trip_shown_a leaves out trips during the power-up phases and while already tripped
   trip_off_a: assert property (trip_event |=> !output_enable) else $error("stage on after trip");
   trip_shown_a: assert property (trip_event && status_code > 4'h3 |=>
      status_code == `TLSD_ST_TRIPPED && shown_trip_code == $past(trip_code)) else $error("trip not shown");
   err_dark_a: assert property (status_code == `TLSD_ST_TRIPPED |-> !output_enable) else $error("stage on");
   idle_dark_a: assert property (status_code inside {`TLSD_ST_INHIBIT, `TLSD_ST_READY} |->
      !output_enable) else $error("stage on while idle");
   uv_dark_a: assert property (status_code == `TLSD_ST_UNDERV |-> !output_enable) else $error("stage on in uv");
   live_stage_a: assert property (status_code inside {`TLSD_ST_STOPPED, `TLSD_ST_SUPPLY_LOSS,
      `TLSD_ST_DC_BRAKE} |-> output_enable) else $error("stage off while live");
   inhibit_cause_a: assert property (!hw_enable && !undervoltage && !trip_event && status_code > 4'h3
      |=> status_code == `TLSD_ST_INHIBIT) else $error("inhibit not shown");
   ps_wait_a: assert property (status_code == `TLSD_ST_WAIT_PS && !power_stage_ready
      |=> status_code == `TLSD_ST_WAIT_PS) else $error("left power stage wait early");
   db_load_a: assert property (status_code == `TLSD_ST_LOAD_DB && db_update
      |=> status_code == `TLSD_ST_LOAD_DB) else $error("left database load early");
   // Live sampling outside a trip; the cycle after a clear still shows tripped and is left out
   mon_live_a: assert property (mon_sample && !trip_event && status_code != `TLSD_ST_TRIPPED
      |=> mon_out == $past(mon_live)) else $error("monitor not updated");
   cover property (trip_event ##1 status_code == `TLSD_ST_TRIPPED);
   cover property (status_code == `TLSD_ST_INHIBIT);
   cover property (trip_clear && status_code == `TLSD_ST_TRIPPED);
endmodule

bind tlsd_trip_log tlsd_trip_log_props u_props (.clk, .rst_n, .trip_event, .trip_clear, .mon_sample, .hw_enable,
   .undervoltage, .power_stage_ready, .db_update, .trip_code, .mon_live, .output_enable, .shown_trip_code,
   .status_code, .mon_out);

// >>> src/tlsd_consts.vh
// Constants for the trip log and status display block.
// Assumes inclusion by bare name from the design file.
`ifndef TLSD_CONSTS_VH
`define TLSD_CONSTS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TLSD_LOG_DEPTH      10
`define TLSD_MON_COUNT      18
`define TLSD_MON_W          16
`define TLSD_CODE_W         8
`define TLSD_DT_W           16

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TLSD_OFF_CTRL       12'h000
`define TLSD_OFF_LOG_RESET  12'h004
`define TLSD_OFF_STATUS     12'h008
`define TLSD_OFF_IRQ_STAT   12'h00c
`define TLSD_OFF_IRQ_MASK   12'h010
`define TLSD_OFF_TRIP_BASE  12'h040
`define TLSD_OFF_SUB_BASE   12'h080
`define TLSD_OFF_DATE_BASE  12'h0c0
`define TLSD_OFF_TIME_BASE  12'h100
`define TLSD_OFF_MON_BASE   12'h140

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define TLSD_CTRL_SW_EN_BIT   0
`define TLSD_CTRL_NOFRZ_BIT   12
`define TLSD_CTRL_ACT_LSB     8
`define TLSD_CTRL_RESET       32'h0000_0000
`define TLSD_LOG_RESET_KEY    8'hff
`define TLSD_IRQ_W            3
`define TLSD_IRQ_TRIP_BIT     0
`define TLSD_IRQ_LOGCLR_BIT   1
`define TLSD_IRQ_TCLR_BIT     2

// ----------------------------------------------------------------
// Status indication codes
// ----------------------------------------------------------------
`define TLSD_ST_WAIT_PS     4'h0
`define TLSD_ST_WAIT_OPT    4'h1
`define TLSD_ST_LOAD_DB     4'h2
`define TLSD_ST_TRIPPED     4'h3
`define TLSD_ST_UNDERV      4'h4
`define TLSD_ST_INHIBIT     4'h5
`define TLSD_ST_READY       4'h6
`define TLSD_ST_STOPPED     4'h7
`define TLSD_ST_SUPPLY_LOSS 4'h8
`define TLSD_ST_DC_BRAKE    4'h9
`define TLSD_ST_RUNNING     4'ha

`endif

// >>> src/tlsd_trip_log.v
// Trip history, monitor freeze and drive status decode behind an APB slave.
// Assumes all inputs synchronous to clk; trip and clear inputs are one-cycle pulses.
`include "tlsd_consts.vh"

module tlsd_trip_log (
   // Clock and reset
   input  wire          clk,
   input  wire          rst_n,
   // APB slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   // Trip source
   input  wire          trip_event,
   input  wire [7:0]    trip_code,
   input  wire          sub_trip_valid,
   input  wire [7:0]    sub_trip,
   input  wire          trip_clear,
   input  wire [15:0]   date_in,
   input  wire [15:0]   time_in,
   // Monitored values
   input  wire          mon_sample,
   input  wire [287:0]  mon_live,
   output reg  [287:0]  mon_out,
   // Drive conditions
   input  wire          hw_enable,
   input  wire          final_run,
   input  wire          zero_speed,
   input  wire          supply_loss,
   input  wire          dc_braking,
   input  wire          undervoltage,
   input  wire          power_stage_ready,
   input  wire          option_fitted,
   input  wire          option_ready,
   input  wire          db_update,
   // Status and control outputs
   output reg  [3:0]    status_code,
   output reg  [7:0]    shown_trip_code,
   output reg           output_enable,
   output reg           irq
);

   // ----------------------------------------------------------------
   // Power-up phases
   // ----------------------------------------------------------------
   localparam [1:0] PU_WAIT_PS  = 2'h0;
   localparam [1:0] PU_WAIT_OPT = 2'h1;
   localparam [1:0] PU_LOAD_DB  = 2'h2;
   localparam [1:0] PU_DONE     = 2'h3;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg  [7:0]              trip_mem [0:`TLSD_LOG_DEPTH-1];
   reg  [7:0]              sub_mem  [0:`TLSD_LOG_DEPTH-1];
   reg  [15:0]             date_mem [0:`TLSD_LOG_DEPTH-1];
   reg  [15:0]             time_mem [0:`TLSD_LOG_DEPTH-1];
   reg  [31:0]             ctrl_reg;
   reg  [`TLSD_IRQ_W-1:0]  irq_stat_reg;
   reg  [`TLSD_IRQ_W-1:0]  irq_mask_reg;
   reg                     tripped_reg;
   reg  [1:0]              pu_reg;
   reg  [1:0]              pu_next;
   reg  [3:0]              status_next;
   reg                     oe_next;
   reg  [31:0]             rdata_next;
   reg                     err_next;
   integer                 i;

   // Bus decode: a transfer takes effect only in the cycle where pready is high,
   // so every write strobe and every read-clear below is qualified by acc_en.
   // Addresses are byte addresses; the two low bits must be zero for a hit.
   // History banks are 64 bytes apart, so a slot index is the word offset
   // inside its bank; indices from ten to fifteen fall through to an error.
   // The monitor bank is 128 bytes wide and holds eighteen words.
   wire        acc_en    = psel & penable & pready;      // Completing access
   wire        wr_en     = acc_en & pwrite;
   wire        rd_en     = acc_en & ~pwrite;
   wire        log_clr   = wr_en && (paddr == `TLSD_OFF_LOG_RESET) &&
                           (pwdata[7:0] == `TLSD_LOG_RESET_KEY);
   wire        sw_enable = ctrl_reg[`TLSD_CTRL_SW_EN_BIT];
   wire        no_freeze = ctrl_reg[`TLSD_CTRL_NOFRZ_BIT];
   wire [11:0] rel_trip  = paddr - `TLSD_OFF_TRIP_BASE;
   wire [11:0] rel_sub   = paddr - `TLSD_OFF_SUB_BASE;
   wire [11:0] rel_date  = paddr - `TLSD_OFF_DATE_BASE;
   wire [11:0] rel_time  = paddr - `TLSD_OFF_TIME_BASE;
   wire [11:0] rel_mon   = paddr - `TLSD_OFF_MON_BASE;
   wire [3:0]  idx_trip  = rel_trip[5:2];
   wire [3:0]  idx_sub   = rel_sub[5:2];
   wire [3:0]  idx_date  = rel_date[5:2];
   wire [3:0]  idx_time  = rel_time[5:2];
   wire [4:0]  idx_mon   = rel_mon[6:2];
   wire [`TLSD_IRQ_W-1:0] irq_events = {trip_clear & tripped_reg, log_clr, trip_event};

   // ----------------------------------------------------------------
   // Trip, sub-trip, date and time history
   // ----------------------------------------------------------------
   // The four histories move as one shift register of ten slots, so a slot
   // index always names the same trip in every bank.
   // Slot zero takes the new entry; the entry in slot nine is lost.
   // A trip that offers no sub-trip number logs zero in the sub-trip bank,
   // so software never sees a stale number from an older trip.
   // Only the low byte of a log-reset write is compared against the key;
   // any other value is ignored without an error response.
   // Clear first so a trip arriving with the clear is still logged
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `TLSD_LOG_DEPTH; i = i + 1) begin
            trip_mem[i] <= 8'h00;
            sub_mem[i]  <= 8'h00;
            date_mem[i] <= 16'h0000;
            time_mem[i] <= 16'h0000;
         end
      end else begin
         if (trip_event) begin
            for (i = `TLSD_LOG_DEPTH-1; i > 0; i = i - 1) begin
               trip_mem[i] <= log_clr ? 8'h00 : trip_mem[i-1];
               sub_mem[i]  <= log_clr ? 8'h00 : sub_mem[i-1];
               date_mem[i] <= log_clr ? 16'h0000 : date_mem[i-1];
               time_mem[i] <= log_clr ? 16'h0000 : time_mem[i-1];
            end
            trip_mem[0] <= trip_code;
            sub_mem[0]  <= sub_trip_valid ? sub_trip : 8'h00;
            date_mem[0] <= date_in;
            time_mem[0] <= time_in;
         end else if (log_clr) begin
            for (i = 0; i < `TLSD_LOG_DEPTH; i = i + 1) begin
               trip_mem[i] <= 8'h00;
               sub_mem[i]  <= 8'h00;
               date_mem[i] <= 16'h0000;
               time_mem[i] <= 16'h0000;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Trip state and monitor freeze
   // ----------------------------------------------------------------
   // A trip and a clear in one cycle leave the drive tripped
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tripped_reg <= 1'b0;
      end else if (trip_event) begin
         tripped_reg <= 1'b1;
      end else if (trip_clear) begin
         tripped_reg <= 1'b0;
      end
   end

   // The monitor copy is taken only on mon_sample, so a freeze simply
   // refuses samples; no second copy of the eighteen values is needed.
   // The trip input itself blocks the sample in its own cycle, so the held
   // values are the last ones seen before the trip.
   // After the clear the very next sample is accepted again.
   // Samples are refused from the trip edge until the clear, unless disabled
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mon_out <= 288'h0;
      end else if (mon_sample) begin
         if (no_freeze || !(tripped_reg || trip_event)) begin
            mon_out <= mon_live;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power-up sequence
   // ----------------------------------------------------------------
   // Waits for the power stage, then for a fitted option module, then for
   // any database update; the done state is left only through reset.
   // A missing option module skips straight to done, since nothing would
   // ever answer and the drive would otherwise hang in the wait phase.
   always @* begin
      pu_next = pu_reg;
      case (pu_reg)
         PU_WAIT_PS: begin
            if (power_stage_ready) begin
               pu_next = option_fitted ? PU_WAIT_OPT : PU_DONE;
            end
         end
         PU_WAIT_OPT: begin
            if (option_ready) begin
               pu_next = db_update ? PU_LOAD_DB : PU_DONE;
            end
         end
         PU_LOAD_DB: begin
            if (!db_update) begin
               pu_next = PU_DONE;
            end
         end
         default: pu_next = PU_DONE;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pu_reg <= PU_WAIT_PS;
      end else begin
         pu_reg <= pu_next;
      end
   end

   // ----------------------------------------------------------------
   // Status decode and output stage
   // ----------------------------------------------------------------
   // Priority order: power-up phases, trip, undervoltage, inhibit, ready,
   // then the live conditions. The stage is on only in the live states.
   // Undervoltage outranks inhibit so a sagging supply is always reported
   // even when the enables are also missing.
   // Braking outranks supply loss and standstill since it is the active
   // action the stage is performing.
   // Trip input acts on the enable in its own cycle so the stage drops at once
   always @* begin
      status_next = `TLSD_ST_RUNNING;
      oe_next     = 1'b1;
      if (pu_reg == PU_WAIT_PS) begin
         status_next = `TLSD_ST_WAIT_PS;
         oe_next     = 1'b0;
      end else if (pu_reg == PU_WAIT_OPT) begin
         status_next = `TLSD_ST_WAIT_OPT;
         oe_next     = 1'b0;
      end else if (pu_reg == PU_LOAD_DB) begin
         status_next = `TLSD_ST_LOAD_DB;
         oe_next     = 1'b0;
      end else if (tripped_reg || trip_event) begin
         status_next = `TLSD_ST_TRIPPED;
         oe_next     = 1'b0;
      end else if (undervoltage) begin
         status_next = `TLSD_ST_UNDERV;
         oe_next     = 1'b0;
      end else if (!hw_enable || !sw_enable) begin
         status_next = `TLSD_ST_INHIBIT;
         oe_next     = 1'b0;
      end else if (!final_run) begin
         status_next = `TLSD_ST_READY;
         oe_next     = 1'b0;
      end else if (dc_braking) begin
         status_next = `TLSD_ST_DC_BRAKE;
      end else if (supply_loss) begin
         status_next = `TLSD_ST_SUPPLY_LOSS;
      end else if (zero_speed) begin
         status_next = `TLSD_ST_STOPPED;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_code     <= `TLSD_ST_WAIT_PS;
         output_enable   <= 1'b0;
         shown_trip_code <= 8'h00;
      end else begin
         status_code     <= status_next;
         output_enable   <= oe_next;
         shown_trip_code <= (tripped_reg || trip_event) ?
                            (trip_event ? trip_code : trip_mem[0]) : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Control, mask and interrupt status registers
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg     <= `TLSD_CTRL_RESET;
         irq_mask_reg <= 3'h0;
      end else if (wr_en) begin
         if (paddr == `TLSD_OFF_CTRL) begin
            ctrl_reg <= {19'h0, pwdata[12:8], 7'h0, pwdata[0]};
         end
         if (paddr == `TLSD_OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`TLSD_IRQ_W-1:0];
         end
      end
   end

   // Bit zero flags a trip, bit one a log clear, bit two a trip clear.
   // A trip clear while not tripped raises nothing, so stray clears from the
   // host do not wake software.
   // The interrupt line lags the status bits by one cycle so that it too
   // comes straight from a flip-flop.
   // Read clears, but an event in the clearing cycle stays set
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= 3'h0;
         irq          <= 1'b0;
      end else begin
         if (rd_en && paddr == `TLSD_OFF_IRQ_STAT) begin
            irq_stat_reg <= irq_events;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_events;
         end
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // APB read mux and decode
   // ----------------------------------------------------------------
   always @* begin
      rdata_next = 32'h0;
      err_next   = 1'b0;
      if (paddr[1:0] != 2'h0) begin
         err_next = 1'b1;
      end else if (paddr == `TLSD_OFF_CTRL) begin
         rdata_next = ctrl_reg;
      end else if (paddr == `TLSD_OFF_LOG_RESET) begin
         rdata_next = 32'h0;
      end else if (paddr == `TLSD_OFF_STATUS) begin
         rdata_next = {15'h0, tripped_reg, shown_trip_code, 4'h0, status_code};
      end else if (paddr == `TLSD_OFF_IRQ_STAT) begin
         rdata_next = {29'h0, irq_stat_reg};
      end else if (paddr == `TLSD_OFF_IRQ_MASK) begin
         rdata_next = {29'h0, irq_mask_reg};
      end else if (paddr >= `TLSD_OFF_TRIP_BASE && idx_trip < 4'd10 && paddr < `TLSD_OFF_SUB_BASE) begin
         rdata_next = {24'h0, trip_mem[idx_trip]};
      end else if (paddr >= `TLSD_OFF_SUB_BASE && idx_sub < 4'd10 && paddr < `TLSD_OFF_DATE_BASE) begin
         rdata_next = {24'h0, sub_mem[idx_sub]};
      end else if (paddr >= `TLSD_OFF_DATE_BASE && idx_date < 4'd10 && paddr < `TLSD_OFF_TIME_BASE) begin
         rdata_next = {16'h0, date_mem[idx_date]};
      end else if (paddr >= `TLSD_OFF_TIME_BASE && idx_time < 4'd10 && paddr < `TLSD_OFF_MON_BASE) begin
         rdata_next = {16'h0, time_mem[idx_time]};
      end else if (paddr >= `TLSD_OFF_MON_BASE && rel_mon[11:7] == 5'h0 && idx_mon < 5'd18) begin
         rdata_next = {16'h0, mon_out[idx_mon*16 +: 16]};
      end else begin
         err_next = 1'b1;
      end
   end

   // Read data is registered on the same edge that raises pready, so the mux above has a
   // full cycle to settle; the cost is one wait state on every transfer.
   // An error response returns zero data and leaves every register unchanged.
   // One wait state: pready rises in the second access cycle, data registered
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & err_next;
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= err_next ? 32'h0 : rdata_next;
         end
      end
   end

endmodule
